// >>> logic/ucc_top.sv
// Purpose: serial transceiver control, frame engine and register slave
// Assumes: AXI4-Lite master keeps one write and one read in flight
// Notes: tx pin is driven only with its output enable high
//
// Our own choices: the AXI4-Lite register port and the register addresses.
module ucc_top
    import ucc_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic sys_rst, // sync reset, active high
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read valid
    input wire logic s_axi_rready, // read ready
    output logic tx_out, // tx pin level
    output logic tx_oe, // tx pin drive enable
    input wire logic rx_in, // rx pin, asynchronous
    output logic rx_active, // receiver owns rx pin
    output logic irq_req // serial irq request pulse
);
    logic [7:0] line_reg, diri_reg, baud_reg, tx_buf_reg, rx_buf_reg;
    logic rx8_reg, tx_full_reg, tx_idle_reg, rx_avail_reg, rx_idle_reg;
    logic ovr_reg, framing_flag_reg, parity_error_flag_reg, nf_reg, armed_reg;
    logic aw_got_reg, w_got_reg;
    logic [7:0] aw_addr_reg;
    logic [7:0] w_data_reg;
    logic w_lane_reg;
    logic rx_s1_reg, rx_s2_reg;
    ucc_tx_state_t tx_st;
    ucc_rx_state_t rx_st;
    logic [5:0] tx_sub_reg, rx_sub_reg;
    logic [3:0] tx_cnt_reg, rx_cnt_reg;
    logic [8:0] tx_sh_reg, rx_sh_reg;
    logic tx_stop2_reg, rx_prev_reg, rx_noise_reg;
    logic tick;

    // register bus decode
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire b_hs = s_axi_bvalid && s_axi_bready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire r_hs = s_axi_rvalid && s_axi_rready;
    wire do_wr = aw_got_reg && w_got_reg && !s_axi_bvalid;
    wire wr_ok = do_wr && w_lane_reg;
    wire wr_line = wr_ok && (aw_addr_reg == ADDR_LINE);
    wire wr_diri = wr_ok && (aw_addr_reg == ADDR_DIRI);
    wire wr_data = wr_ok && (aw_addr_reg == ADDR_DATA);
    wire wr_baud = wr_ok && (aw_addr_reg == ADDR_BAUD);
    wire wr_map = (aw_addr_reg == ADDR_STATUS) || (aw_addr_reg == ADDR_LINE)
        || (aw_addr_reg == ADDR_DIRI) || (aw_addr_reg == ADDR_DATA)
        || (aw_addr_reg == ADDR_BAUD);
    wire rd_status = ar_hs && (s_axi_araddr == ADDR_STATUS);
    wire rd_data = ar_hs && (s_axi_araddr == ADDR_DATA);
    wire [7:0] status_val = {parity_error_flag_reg, nf_reg, framing_flag_reg, ovr_reg,
        rx_idle_reg, rx_avail_reg, tx_idle_reg, !tx_full_reg};
    wire [7:0] line_val = {line_reg[7:2], rx8_reg, 1'b0};
    wire [7:0] rd_val = (s_axi_araddr == ADDR_STATUS) ? status_val :
        (s_axi_araddr == ADDR_LINE) ? line_val :
        (s_axi_araddr == ADDR_DIRI) ? diri_reg :
        (s_axi_araddr == ADDR_DATA) ? rx_buf_reg :
        (s_axi_araddr == ADDR_BAUD) ? baud_reg : 8'h00;
    wire rd_map = (s_axi_araddr == ADDR_STATUS) || (s_axi_araddr == ADDR_LINE)
        || (s_axi_araddr == ADDR_DIRI) || (s_axi_araddr == ADDR_DATA)
        || (s_axi_araddr == ADDR_BAUD);

    // control bits and the unit-off forcing
    wire [7:0] line_base = wr_line ? w_data_reg : line_reg;
    wire [7:0] diri_base = wr_diri ? w_data_reg : diri_reg;
    wire unit_on = line_reg[B_UNIT_ON];
    wire [7:0] line_next = line_base[B_UNIT_ON] ? line_base : (line_base & LINE_OFF_MASK);
    wire [7:0] diri_next = line_base[B_UNIT_ON] ? diri_base : (diri_base & DIRI_OFF_MASK);
    wire nine = line_reg[B_NINE];
    wire par_on = line_reg[B_PAR_ON];
    wire par_odd = line_reg[B_PAR_ODD];
    wire two_stop = line_reg[B_TWO_STOP];
    wire send_brk = line_reg[B_BREAK];
    wire tx_run = unit_on && diri_reg[B_TX_ON];
    wire rx_run = unit_on && diri_reg[B_RX_ON];
    wire [3:0] last_bit = nine ? LAST_BIT_9 : LAST_BIT_8;
    wire [5:0] osr_last = diri_reg[B_HIGH_SPD] ? OSR_HIGH_LAST : OSR_LOW_LAST;
    wire [5:0] osr_half = {1'b0, osr_last[5:1]};

    ucc_baud u_baud (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .run(unit_on),
        .divisor(baud_reg),
        .tick(tick)
    );

    // transmit frame building
    wire tx_bit_end = tick && (tx_sub_reg == osr_last);
    wire tx_par = (nine ? ^tx_buf_reg : ^tx_buf_reg[6:0]) ^ par_odd;
    // ninth bit from parity if on, else from the write-only bit
    wire tx_msb = par_on ? tx_par : (nine ? line_reg[0] : tx_buf_reg[7]);
    wire [8:0] tx_word = nine ? {tx_msb, tx_buf_reg} : {1'b0, tx_msb, tx_buf_reg[6:0]};
    wire tx_load = (tx_st == T_IDLE) && tx_full_reg;

    // receive word checks
    wire rxd = rx_s2_reg;
    wire rx_bit_end = tick && (rx_sub_reg == osr_last);
    wire rx_done = (rx_st == R_STOP) && rx_bit_end;
    wire [8:0] rx_word = nine ? rx_sh_reg : {1'b0, rx_sh_reg[8:1]};
    wire addr_bit = nine ? rx_word[8] : rx_word[7];
    wire rx_drop = diri_reg[B_ADDR_DET] && !addr_bit;
    wire rx_push = rx_done && !rx_drop && !rx_avail_reg;
    wire ovr_set = rx_done && !rx_drop && rx_avail_reg;
    wire rx_parity_error_flag = par_on && ((nine ? ^rx_word : ^rx_word[7:0]) ^ par_odd);
    wire rx_clr = rd_data && armed_reg;

    // bus write channel
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_got_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_hs)
            begin
                w_got_reg <= 1'b1;
                w_data_reg <= s_axi_wdata[7:0];
                w_lane_reg <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_wr)
            begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end
            if (b_hs)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // bus read channel
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (ar_hs)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_val};
            s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end
        else if (r_hs)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // control registers reset to 8N1, off
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            line_reg <= LINE_RST;
            diri_reg <= DIRI_RST;
            baud_reg <= BAUD_RST;
        end
        else
        begin
            line_reg <= line_next;
            diri_reg <= diri_next;
            baud_reg <= wr_baud ? w_data_reg : baud_reg;
        end
    end

    // transmit engine
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !tx_run)
        begin
            tx_st <= T_IDLE;
            tx_full_reg <= 1'b0;
            tx_sub_reg <= 6'h00;
            tx_cnt_reg <= 4'h0;
            tx_stop2_reg <= 1'b0;
            tx_out <= 1'b1;
        end
        else
        begin
            tx_sub_reg <= (tick && (tx_st != T_IDLE)) ? (tx_bit_end ? 6'h00 : tx_sub_reg + 6'h01)
                : tx_sub_reg;
            if (wr_data)
            begin
                tx_buf_reg <= w_data_reg;
                tx_full_reg <= 1'b1;
            end
            else if (tx_load)
                tx_full_reg <= 1'b0;
            unique case (tx_st)
                T_IDLE:
                begin
                    tx_out <= !(send_brk && !tx_full_reg);
                    tx_sub_reg <= 6'h00;
                    tx_cnt_reg <= 4'h0;
                    if (tx_full_reg)
                    begin
                        tx_sh_reg <= tx_word;
                        tx_st <= T_START;
                        tx_out <= 1'b0;
                    end
                    else if (send_brk)
                        tx_st <= T_BRK;
                end
                T_START:
                begin
                    tx_out <= 1'b0;
                    if (tx_bit_end)
                    begin
                        tx_st <= T_DATA;
                        tx_out <= tx_sh_reg[0];
                    end
                end
                T_DATA:
                begin
                    if (tx_bit_end)
                    begin
                        tx_sh_reg <= {1'b0, tx_sh_reg[8:1]};
                        tx_out <= (tx_cnt_reg == last_bit) ? 1'b1 : tx_sh_reg[1];
                        tx_cnt_reg <= tx_cnt_reg + 4'h1;
                        tx_stop2_reg <= 1'b0;
                        if (tx_cnt_reg == last_bit)
                            tx_st <= T_STOP;
                    end
                end
                T_STOP:
                begin
                    tx_out <= 1'b1;
                    if (tx_bit_end)
                    begin
                        if (two_stop && !tx_stop2_reg)
                            tx_stop2_reg <= 1'b1;
                        else
                            tx_st <= T_IDLE;
                    end
                end
                T_BRK:
                begin
                    // low for at least thirteen bits
                    tx_out <= 1'b0;
                    if (tx_bit_end && (tx_cnt_reg != BREAK_BITS))
                        tx_cnt_reg <= tx_cnt_reg + 4'h1;
                    if ((tx_cnt_reg == BREAK_BITS) && !send_brk)
                    begin
                        tx_st <= T_IDLE;
                        tx_out <= 1'b1;
                    end
                end
                default:
                    tx_st <= T_IDLE;
            endcase
        end
    end

    // receive engine
    always_ff @(posedge clk_sys)
    begin
        rx_s1_reg <= rx_in;
        rx_s2_reg <= rx_s1_reg;
        if (sys_rst || !rx_run)
        begin
            rx_st <= R_IDLE;
            rx_sub_reg <= 6'h00;
            rx_cnt_reg <= 4'h0;
            rx_noise_reg <= 1'b0;
        end
        else
        begin
            if (tick)
            begin
                rx_prev_reg <= rxd;
                rx_sub_reg <= (rx_sub_reg == osr_last) ? 6'h00 : rx_sub_reg + 6'h01;
            end
            unique case (rx_st)
                R_IDLE:
                begin
                    rx_sub_reg <= 6'h00;
                    rx_cnt_reg <= 4'h0;
                    rx_noise_reg <= 1'b0;
                    if (!rxd)
                        rx_st <= R_START;
                end
                R_START:
                begin
                    if (tick && (rx_sub_reg == osr_half))
                    begin
                        rx_sub_reg <= 6'h00;
                        rx_st <= rxd ? R_IDLE : R_DATA;
                    end
                end
                R_DATA:
                begin
                    if (rx_bit_end)
                    begin
                        rx_sh_reg <= {rxd, rx_sh_reg[8:1]};
                        rx_noise_reg <= rx_noise_reg || (rxd != rx_prev_reg);
                        rx_cnt_reg <= rx_cnt_reg + 4'h1;
                        if (rx_cnt_reg == last_bit)
                            rx_st <= R_STOP;
                    end
                end
                R_STOP:
                begin
                    if (rx_bit_end)
                        rx_st <= R_IDLE;
                end
                default:
                    rx_st <= R_IDLE;
            endcase
        end
    end

    // status flags, set wins over software clear
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !unit_on)
        begin
            rx_avail_reg <= 1'b0;
            ovr_reg <= 1'b0;
            framing_flag_reg <= 1'b0;
            parity_error_flag_reg <= 1'b0;
            nf_reg <= 1'b0;
            tx_idle_reg <= 1'b1;
            rx_idle_reg <= 1'b1;
            armed_reg <= 1'b0;
            rx_buf_reg <= 8'h00;
            rx8_reg <= 1'b0;
            irq_req <= 1'b0;
        end
        else
        begin
            armed_reg <= rd_status || (armed_reg && !rd_data && !wr_data);
            tx_idle_reg <= (tx_st == T_IDLE) && !tx_full_reg && !send_brk && !wr_data;
            rx_idle_reg <= (rx_st == R_IDLE);
            irq_req <= diri_reg[B_RX_IRQ] && (rx_push || ovr_set);
            if (!rx_run)
                rx_avail_reg <= 1'b0;
            else if (rx_push)
            begin
                rx_buf_reg <= rx_word[7:0];
                rx8_reg <= rx_word[8];
                rx_avail_reg <= 1'b1;
                framing_flag_reg <= !rxd;
                parity_error_flag_reg <= rx_parity_error_flag;
                nf_reg <= rx_noise_reg;
            end
            else if (rx_clr)
            begin
                rx_avail_reg <= 1'b0;
                framing_flag_reg <= 1'b0;
                parity_error_flag_reg <= 1'b0;
                nf_reg <= 1'b0;
            end
            if (ovr_set)
                ovr_reg <= 1'b1;
            else if (rx_clr)
                ovr_reg <= 1'b0;
        end
    end

    // pin drive
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            tx_oe <= 1'b0;
            rx_active <= 1'b0;
        end
        else
        begin
            tx_oe <= tx_run;
            rx_active <= rx_run;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    logic [11:0] brk_low_reg;
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || tx_st != T_BRK)
            brk_low_reg <= 12'h000;
        else if (brk_low_reg != 12'hfff)
            brk_low_reg <= brk_low_reg + 12'h001;
    end

    AST_OFF_FLOAT: assert property (!unit_on |=> !tx_oe && !rx_active)
        else $error("pins not floated while unit off");
    AST_OFF_FLAGS: assert property (!unit_on |-> !diri_reg[B_TX_ON] && !diri_reg[B_RX_ON]
        && !line_reg[B_BREAK] ##1 (!rx_avail_reg && tx_idle_reg && !tx_full_reg && rx_idle_reg))
        else $error("unit off did not reset flags");
    AST_ON_DRIVE: assert property (tx_run && rx_run |=> tx_oe && rx_active)
        else $error("enabled pins not driven");
    AST_TX_OFF: assert property (!tx_run |=> tx_st == T_IDLE && !tx_full_reg && tx_out)
        else $error("transmitter not reset when off");
    AST_RX_OFF: assert property (!rx_run |=> rx_st == R_IDLE && !rx_avail_reg)
        else $error("receiver not reset when off");
    AST_BRK_LEN: assert property ((tx_st == T_BRK) && tx_run ##1 (tx_st == T_IDLE)
        |-> $past(brk_low_reg) >= 12'd207 && !$past(send_brk))
        else $error("break shorter than thirteen bits");
    AST_DROP: assert property (rx_done && rx_drop && rx_run |=> !irq_req
        && !$rose(rx_avail_reg))
        else $error("discarded word raised flag");
    AST_RX_IRQ: assert property (rx_push && rx_run && diri_reg[B_RX_IRQ] |=> irq_req
        && rx_avail_reg)
        else $error("receive irq missing");
    AST_STOP_IDLE: assert property ($rose(tx_oe) |-> tx_out [*2])
        else $error("tx pin not idle high at enable");
endmodule : ucc_top

// >>> include/ucc_pkg.sv
// Purpose: shared constants and types of the serial control block
// Assumes: 250 MHz clk_sys, AXI4-Lite register access
// Notes: register offsets are byte addresses
// Contract
// - unit off disables transceiver, both pins float
// - unit off empties buffer and resets baud counter
// - unit off clears enables, break, rx flags; sets idle and empty
// - unit off aborts transfers at once; re-enable keeps configuration
// - unit on: pins follow transmitter and receiver enables
// - nine-bit select picks 8 or 9 bit frames; ninth bits stored
// - parity on replaces data msb with parity, checked on receive
// - parity odd select: 0 even, 1 odd
// - two stop select: 0 one stop bit, 1 two
// - send break: after buffered data, low at least 13 bits, until cleared
// - transmitter off aborts, resets tx buffer, floats tx pin
// - tx pin driven only with transmitter and unit on
// - receiver off aborts, resets rx buffer, rx pin floats
// - receiver runs only with receiver and unit on
// - baud high speed selects fast mode; divisor sets rate
// - address detect: word with address bit 1 accepted, irq raised
// - address detect: word with address bit 0 discarded, no irq
// - free 8-bit timer: clk/(64(N+1)) slow, clk/(16(N+1)) fast
// - receive irq on: overrun or rx available sets irq request
package ucc_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_LINE = 8'h04;
    localparam logic [7:0] ADDR_DIRI = 8'h08;
    localparam logic [7:0] ADDR_DATA = 8'h0c;
    localparam logic [7:0] ADDR_BAUD = 8'h10;
    localparam logic [7:0] LINE_RST = 8'h00;
    localparam logic [7:0] DIRI_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [7:0] LINE_OFF_MASK = 8'hfb;
    localparam logic [7:0] DIRI_OFF_MASK = 8'h3f;
    localparam int B_UNIT_ON = 7;
    localparam int B_NINE = 6;
    localparam int B_PAR_ON = 5;
    localparam int B_PAR_ODD = 4;
    localparam int B_TWO_STOP = 3;
    localparam int B_BREAK = 2;
    localparam int B_TX_ON = 7;
    localparam int B_RX_ON = 6;
    localparam int B_HIGH_SPD = 5;
    localparam int B_ADDR_DET = 4;
    localparam int B_RX_IRQ = 2;
    localparam logic [5:0] OSR_LOW_LAST = 6'h3f;
    localparam logic [5:0] OSR_HIGH_LAST = 6'h0f;
    localparam logic [3:0] BREAK_BITS = 4'hd;
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        T_IDLE = 3'b000, T_START = 3'b001, T_DATA = 3'b011, T_STOP = 3'b010, T_BRK = 3'b110
    } ucc_tx_state_t;
    typedef enum logic [1:0] {
        R_IDLE = 2'b00, R_START = 2'b01, R_DATA = 2'b11, R_STOP = 2'b10
    } ucc_rx_state_t;
endpackage : ucc_pkg

// >>> logic/ucc_baud.sv
// Purpose: free running baud timer, one tick per divisor+1 clocks
// Assumes: run low holds the count at zero
// Notes: bit time is 16 or 64 ticks, counted by the user
module ucc_baud
    import ucc_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic sys_rst, // sync reset
    input wire logic run, // timer enable
    input wire logic [7:0] divisor, // divisor value
    output logic tick // one-cycle sample tick
);
    logic [7:0] cnt_reg;
    wire at_end = (cnt_reg == divisor);

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !run)
        begin
            cnt_reg <= 8'h00;
            tick <= 1'b0;
        end
        else
        begin
            cnt_reg <= at_end ? 8'h00 : cnt_reg + 8'h01;
            tick <= at_end;
        end
    end
endmodule : ucc_baud

// >>> sim/ucc_peer.sv
// Purpose: remote serial peer on the tx and rx pins
// Assumes: fixed bit time in clocks, 8 data bits, lsb first
// Notes: a floating tx pin reads high through the pull-up
module ucc_peer #(
    parameter int BIT = 16
) (
    input wire logic clk_sys, // system clock
    input wire logic tx_out, // device tx level
    input wire logic tx_oe, // device tx drive enable
    output logic rx_line // line into device rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got;
    int n_got = 0;
    wire line = tx_oe ? tx_out : 1'b1;
    initial rx_line = 1'b1;
    // one stop bit, idle high after
    task automatic send(input logic [7:0] w);
        rx_line <= 1'b0;
        repeat (BIT) @(posedge clk_sys);
        for (int i = 0; i < 8; i++)
        begin
            rx_line <= w[i];
            repeat (BIT) @(posedge clk_sys);
        end
        rx_line <= 1'b1;
        repeat (BIT) @(posedge clk_sys);
    endtask : send
    // sample mid bit after each start edge
    always
    begin
        @(negedge line);
        repeat (BIT / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge clk_sys);
            got[i] = line;
        end
        n_got++;
    end
endmodule : ucc_peer

// >>> sim/uart_control_config_tb.sv
// Purpose: register-level bench of the serial control block
// Assumes: divisor 0 in high speed mode, 16 clocks a bit
// Notes: peer model answers on the serial pins
module uart_control_config_tb import ucc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic tx_out, tx_oe, rx_in, rx_active, irq_req;
    int mismatches = 0;
    int n_compared = 0;
    int n_irq = 0;
    int k0;
    ucc_top u_ucc_top (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_out, .tx_oe, .rx_in, .rx_active,
        .irq_req);
    ucc_peer #(.BIT(16)) u_peer (.clk_sys, .tx_out, .tx_oe, .rx_line(rx_in));
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (irq_req === 1'b1) n_irq <= n_irq + 1;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        rr = s_axi_rresp;
    endtask : rd
    task automatic wait_got(input int n);
        for (int t = 0; t < 400 && u_peer.n_got == n; t++) @(posedge clk_sys);
        repeat (40) @(posedge clk_sys);
    endtask : wait_got
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        final_report();
    end
    initial
    begin
        {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        rd(ADDR_LINE, d, r);
        chk(d, 32'h0);
        rd(ADDR_DIRI, d, r);
        chk(d, 32'h0);
        chk(tx_oe, 0);
        rd(8'h14, d, r);
        chk(r, RESP_SLVERR);
        $display("reset test done");
        for (int k = 0; k < 2; k++)
        begin
            wr(ADDR_LINE, 8'ha0 | (k[0] ? 8'h10 : 8'h00));
            wr(ADDR_DIRI, 8'he4);
            @(posedge clk_sys);
            chk(tx_oe, 1);
            k0 = u_peer.n_got;
            wr(ADDR_DATA, 8'h03);
            wait_got(k0);
            chk(u_peer.n_got, k0 + 1);
            chk(u_peer.got, {24'h0, k[0] ^ (^7'h03), 7'h03});
        end
        $display("transmit parity test done");
        wr(ADDR_LINE, 8'h80);
        u_peer.send(8'ha5);
        rd(ADDR_STATUS, d, r);
        chk(d[2], 1);
        rd(ADDR_DATA, d, r);
        chk(d, 32'ha5);
        wr(ADDR_DIRI, 8'hf4);
        k0 = n_irq;
        u_peer.send(8'h25);
        repeat (20) @(posedge clk_sys);
        rd(ADDR_STATUS, d, r);
        chk(d[2], 0);
        chk(n_irq, k0);
        u_peer.send(8'h85);
        repeat (20) @(posedge clk_sys);
        rd(ADDR_STATUS, d, r);
        chk(d[2], 1);
        chk(n_irq, k0 + 1);
        rd(ADDR_DATA, d, r);
        chk(d, 32'h85);
        $display("receive address test done");
        wr(ADDR_LINE, 8'h84);
        repeat (13 * 16 + 8) @(posedge clk_sys);
        chk(tx_out, 0);
        wr(ADDR_LINE, 8'h80);
        @(posedge clk_sys);
        chk(tx_out, 1);
        wr(ADDR_LINE, 8'h00);
        @(posedge clk_sys);
        chk({tx_oe, rx_active}, 0);
        rd(ADDR_DIRI, d, r);
        chk(d, 32'h34);
        rd(ADDR_STATUS, d, r);
        chk(d, 32'h0b);
        wr(ADDR_LINE, 8'h80);
        rd(ADDR_DIRI, d, r);
        chk(d, 32'h34);
        $display("break and unit off test done");
        final_report();
    end
endmodule : uart_control_config_tb
